// ==== rtl/escp_pkg.sv ====
// package: constants and types for the stop status and charge-pump watchdog
package escp_pkg;

    //----------------------------------------------------------------
    // stop mode selection
    //----------------------------------------------------------------
    typedef enum logic [1:0] {
        ESCP_MODE_NORMAL,
        ESCP_MODE_SIGNAL_ONLY,
        ESCP_MODE_OPEN
    } escp_mode_e;

    //----------------------------------------------------------------
    // timing
    //----------------------------------------------------------------
    localparam int ESCP_CLK_MHZ       = 100;
    // default silence window of the watchdog line, in microseconds
    localparam int ESCP_WD_TIMEOUT_US = 100;
    localparam int ESCP_WD_TIMEOUT_CYC = ESCP_WD_TIMEOUT_US * ESCP_CLK_MHZ;
    localparam int ESCP_WD_CNT_W      = 24;

    localparam logic [1:0] ESCP_SYNC_RST = 2'h0;
    // stages of the edge-detector priming chain after reset
    localparam int         ESCP_PRIME_W  = 3;
    localparam logic       ESCP_BIT_SET  = 1'h1;
    localparam logic       ESCP_BIT_CLR  = 1'h0;

    //----------------------------------------------------------------
    // outputs and state
    //----------------------------------------------------------------
    typedef struct packed {
        logic status_out;     // to host status line, high = stop
        logic stop_indicator; // lamp drive, high = lit
        logic ctrl_oe;        // control output buffer enable
        logic bus_oe;         // data bus buffer enable
        logic relay_on;       // relay drive, high = energised
        logic wd_ok;          // watchdog healthy
    } escp_out_s;

    typedef struct packed {
        logic [1:0]               stop_sync;
        logic [1:0]               fault_n_sync;
        logic [1:0]               wd_sync;
        logic                     wd_last;
        logic [ESCP_PRIME_W-1:0]  wd_prime;
        logic [ESCP_WD_CNT_W-1:0] wd_cnt;
        escp_out_s                out;
    } escp_state_s;

endpackage : escp_pkg

// ==== rtl/escp_watchdog.sv ====
// module: stop status forwarding and charge-pump watchdog gating
`timescale 1ns/100ps
module escp_watchdog
    import escp_pkg::*;
#(
    parameter int WD_TIMEOUT_CYC = ESCP_WD_TIMEOUT_CYC
) (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       clk_en,
    input  wire logic       estop_in,
    input  wire logic       fault_n_in,
    input  wire logic       wd_line_in,
    input  wire escp_mode_e stop_mode_select,
    input  wire logic       ctrl_watchdog_gate_select,
    input  wire logic       bus_disable_select,
    output escp_out_s       outs
);

    //----------------------------------------------------------------
    // state
    //----------------------------------------------------------------
    escp_state_s st;
    escp_state_s next_st;

    localparam logic [ESCP_WD_CNT_W-1:0] WD_LIMIT =
        ESCP_WD_CNT_W'(WD_TIMEOUT_CYC - 1);
    localparam logic [ESCP_WD_CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [ESCP_WD_CNT_W-1:0] CNT_ONE  = ESCP_WD_CNT_W'(1);

    //----------------------------------------------------------------
    // helper functions
    //----------------------------------------------------------------

    // one step of a two-stage synchroniser: the pin enters stage one,
    // stage one moves on to stage two; only stage two is ever decoded
    function automatic logic [1:0] escp_shift2(
        input logic [1:0] stages,
        input logic       pin
    );
        return {stages[0], pin};
    endfunction : escp_shift2

    // normal stop mode: both stop conditions act on the buffers
    function automatic logic escp_is_normal(
        input escp_mode_e mode
    );
        return (mode == ESCP_MODE_NORMAL);
    endfunction : escp_is_normal

    // status line value: in normal mode the stop and fault conditions
    // are ORed; in the other modes the stop input passes straight on,
    // never inverted, so a high stop input reads high on the host side
    function automatic logic escp_stop_cond(
        input logic normal,
        input logic stop_act,
        input logic fault_act
    );
        return normal ? (stop_act | fault_act) : stop_act;
    endfunction : escp_stop_cond

    // a stop condition only cuts outputs in normal mode; signal-only
    // and open leave relay and buffers alone
    function automatic logic escp_stop_cut(
        input logic normal,
        input logic stop_cond
    );
        return normal & stop_cond;
    endfunction : escp_stop_cut

    // control buffer enable: off on a cut, and off on a failed watchdog
    // only where the gate select asks for it
    function automatic logic escp_ctrl_enable(
        input logic cut,
        input logic gate_sel,
        input logic wd_ok
    );
        return ~cut & ~(gate_sel & ~wd_ok);
    endfunction : escp_ctrl_enable

    // data bus enable: never dropped unless the bus select allows it;
    // when allowed, a cut or a failed watchdog drops it
    function automatic logic escp_bus_enable(
        input logic cut,
        input logic bus_sel,
        input logic wd_ok
    );
        return ~(bus_sel & (cut | ~wd_ok));
    endfunction : escp_bus_enable

    // level change on the synchronised watchdog line; masked until the
    // priming chain is full, so the zero left in the sync stages by
    // reset cannot pass for a toggle and fake a healthy host
    function automatic logic escp_wd_edge(
        input logic now_lvl,
        input logic last_lvl,
        input logic primed
    );
        return primed & (now_lvl ^ last_lvl);
    endfunction : escp_wd_edge

    //----------------------------------------------------------------
    // next-state logic
    //----------------------------------------------------------------
    always_comb begin
        logic stop_act;
        logic fault_act;
        logic stop_cond;
        logic wd_edge;
        logic normal;
        logic cut;
        stop_act  = 1'b0;
        fault_act = 1'b0;
        stop_cond = 1'b0;
        wd_edge   = 1'b0;
        normal    = 1'b0;
        cut       = 1'b0;
        next_st   = st;

        // input synchronisers; only the second stage is read below
        next_st.stop_sync    = escp_shift2(st.stop_sync,
                                           estop_in);
        next_st.fault_n_sync = escp_shift2(st.fault_n_sync,
                                           fault_n_in);
        next_st.wd_sync      = escp_shift2(st.wd_sync,
                                           wd_line_in);
        // priming chain fills with ones after reset
        next_st.wd_prime = {st.wd_prime[ESCP_PRIME_W-2:0],
                            ESCP_BIT_SET};

        stop_act  = st.stop_sync[1];
        fault_act = ~st.fault_n_sync[1];
        normal    = escp_is_normal(stop_mode_select);

        // status and lamp: no watchdog term anywhere here
        stop_cond = escp_stop_cond(normal, stop_act,
                                   fault_act);
        next_st.out.status_out     = stop_cond;
        next_st.out.stop_indicator = stop_cond;

        // watchdog: any level change once the priming chain is full restarts the silence count
        next_st.wd_last = st.wd_sync[1];
        wd_edge = escp_wd_edge(st.wd_sync[1], st.wd_last,
                               st.wd_prime[ESCP_PRIME_W-1]);
        if (wd_edge) begin
            next_st.wd_cnt    = CNT_ZERO;
            next_st.out.wd_ok = ESCP_BIT_SET;
        end else if (st.wd_cnt >= WD_LIMIT) begin
            next_st.out.wd_ok = ESCP_BIT_CLR;
        end else begin
            next_st.wd_cnt = st.wd_cnt + CNT_ONE;
        end

        // control buffers: stop condition (normal) and optional watchdog
        cut = escp_stop_cut(normal, stop_cond);
        next_st.out.ctrl_oe = escp_ctrl_enable(cut,
            ctrl_watchdog_gate_select, st.out.wd_ok);
        // relay drops on a stop condition in normal mode
        next_st.out.relay_on = ~cut;
        // data bus may only be disabled when allowed at all
        next_st.out.bus_oe = escp_bus_enable(cut,
            bus_disable_select, st.out.wd_ok);
    end

    //----------------------------------------------------------------
    // state register; watchdog starts failed
    //----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st                    <= '0;
            st.stop_sync          <= ESCP_SYNC_RST;
            st.fault_n_sync       <= ESCP_SYNC_RST;
            st.out.wd_ok          <= ESCP_BIT_CLR;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign outs = st.out;

endmodule : escp_watchdog

// ==== tb/escp_host_model.sv ====
// model: host port that toggles the watchdog line
`timescale 1ns/100ps
module escp_host_model (
    input  wire logic mclk,
    input  wire logic run,
    input  wire logic status_line,
    output logic      wd_line
);
    int   div = 0;
    logic go  = 0;
    initial wd_line = 0;
    // start only on a clear status line, then toggle every third cycle
    always @(posedge mclk) begin
        #1;
        go = run && (go || !status_line);
        div = go ? (div + 1) % 3 : 0;
        if (go && div == 0) wd_line = ~wd_line;
    end
endmodule : escp_host_model

// ==== tb/escp_watchdog_assertions.sv ====
// checker: port assertions for the stop status and watchdog block
`timescale 1ns/100ps
module escp_watchdog_assertions
    import escp_pkg::*;
#(parameter int WD_TIMEOUT_CYC = 20) (
    input wire logic       mclk,
    input wire logic       rstn,
    input wire logic       clk_en,
    input wire logic       estop_in,
    input wire logic       fault_n_in,
    input wire logic       wd_line_in,
    input wire escp_mode_e stop_mode_select,
    input wire logic       ctrl_watchdog_gate_select,
    input wire logic       bus_disable_select,
    input wire escp_out_s  outs
);
    int up;
    int quiet;
    // settle count after reset and cycles since the last line change
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            up <= 0;
            quiet <= 0;
        end else begin
            up <= !clk_en ? 0 : ((up < 5) ? up + 1 : up);
            quiet <= $changed(wd_line_in) ? 0 : quiet + 1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn || !clk_en);
    sequence s_tog; $changed(wd_line_in); endsequence
    a_status_or: assert property (
        up == 5 |-> outs.status_out == ($past(estop_in, 3) ||
        ($past(stop_mode_select) == ESCP_MODE_NORMAL && !$past(fault_n_in, 3))))
        else $error("status line wrong");
    a_lamp_follow: assert property (
        outs.stop_indicator == outs.status_out) else $error("lamp wrong");
    a_stop_cuts: assert property (
        outs.status_out && $past(stop_mode_select) == ESCP_MODE_NORMAL
        |-> !outs.ctrl_oe && !outs.relay_on) else $error("stop not cut");
    a_ctrl_free: assert property (
        up == 5 && !$past(ctrl_watchdog_gate_select) &&
        $past(stop_mode_select) != ESCP_MODE_NORMAL |-> outs.ctrl_oe)
        else $error("ctrl disabled");
    a_bus_free: assert property (
        up == 5 && !$past(bus_disable_select) |-> outs.bus_oe)
        else $error("bus disabled");
    a_ctrl_wd: assert property (
        up == 5 && $past(ctrl_watchdog_gate_select) && !$past(outs.wd_ok)
        |-> !outs.ctrl_oe) else $error("ctrl not gated");
    a_wd_quiet: assert property (
        quiet > WD_TIMEOUT_CYC + 12 |-> !outs.wd_ok) else $error("wd not failed");
    a_wd_live: assert property (
        s_tog ##3 s_tog |-> ##[4:6] outs.wd_ok) else $error("wd not healthy");
endmodule : escp_watchdog_assertions

// ==== tb/tb_top.sv ====
// bench: checks the stop status and charge-pump watchdog block
`timescale 1ns/100ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
    fail_count++; $display("unexpected %s exp %b got %b", n, e, s); end end
module tb_top
    import escp_pkg::*;
;
    localparam int TO = 20;
    logic mclk = 0, rstn = 0, estop = 0, fault_n = 1, wd;
    logic run = 0, gate = 1, bdis = 1, chk = 0, ce = 1;
    escp_mode_e mode = ESCP_MODE_NORMAL;
    escp_out_s  outs;
    int fail_count = 0, samples_checked = 0, q[$], e;
    always #5 mclk = ~mclk;
    escp_watchdog #(.WD_TIMEOUT_CYC(TO)) i_escp_watchdog (.mclk(mclk),
        .rstn(rstn), .clk_en(ce), .estop_in(estop), .fault_n_in(fault_n),
        .wd_line_in(wd), .stop_mode_select(mode), .outs(outs),
        .ctrl_watchdog_gate_select(gate), .bus_disable_select(bdis));
    escp_host_model i_escp_host_model (.mclk(mclk), .run(run),
        .status_line(outs.status_out), .wd_line(wd));
    // reference model: status three edges after the inputs, read mid-cycle
    always @(negedge mclk) if (chk) begin
        q.push_back(estop || (mode == ESCP_MODE_NORMAL && !fault_n));
        if (q.size() > 3) begin
            e = q.pop_front();
            `CHK("status", e[0], outs.status_out)
            `CHK("lamp", e[0], outs.stop_indicator)
            `CHK("ctrl", !(e[0] && mode == ESCP_MODE_NORMAL), outs.ctrl_oe)
            `CHK("relay", !(e[0] && mode == ESCP_MODE_NORMAL), outs.relay_on)
            `CHK("bus", !(e[0] && mode == ESCP_MODE_NORMAL), outs.bus_oe)
        end
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    task automatic tick(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    initial begin #20000; fail_count++; stop_test(); end
    // random stop and fault levels in every mode, then the watchdog
    initial begin
        void'($urandom(32'hC765));
        tick(5); rstn = 1; run = 1; tick(30);
        for (int m = 0; m < 3; m++) begin
            mode = escp_mode_e'(m); tick(4); q.delete(); chk = 1;
            repeat (40) begin
                estop = ($urandom % 4) == 0; fault_n = ($urandom % 4) != 0; tick(1);
            end
            chk = 0; estop = 0; fault_n = 1; $display("mode test %0d done", m);
        end
        rstn = 0; run = 0; mode = ESCP_MODE_SIGNAL_ONLY; tick(1);
        `CHK("wd reset", 1'h0, outs.wd_ok)
        rstn = 1; tick(TO + 20);
        `CHK("wd idle", 1'h0, outs.wd_ok)
        `CHK("ctrl gated", 1'h0, outs.ctrl_oe)
        `CHK("bus gated", 1'h0, outs.bus_oe)
        `CHK("status clear", 1'h0, outs.status_out)
        gate = 0; bdis = 0; tick(3);
        `CHK("ctrl bypass", 1'h1, outs.ctrl_oe)
        `CHK("bus bypass", 1'h1, outs.bus_oe)
        gate = 1; bdis = 1; run = 1; tick(16);
        `CHK("wd live", 1'h1, outs.wd_ok)
        `CHK("ctrl live", 1'h1, outs.ctrl_oe)
        ce = 0; estop = 1; tick(6);
        `CHK("freeze status", 1'h0, outs.status_out)
        `CHK("freeze wd", 1'h1, outs.wd_ok)
        ce = 1; tick(4);
        `CHK("stop forward", 1'h1, outs.status_out)
        `CHK("ctrl unaffected", 1'h1, outs.ctrl_oe)
        `CHK("relay unaffected", 1'h1, outs.relay_on)
        estop = 0;
        $display("watchdog test done");
        stop_test();
    end
endmodule : tb_top
bind escp_watchdog escp_watchdog_assertions #(.WD_TIMEOUT_CYC(WD_TIMEOUT_CYC))
    i_chk (.mclk(mclk), .rstn(rstn), .clk_en(clk_en), .estop_in(estop_in),
    .outs(outs),
    .fault_n_in(fault_n_in), .wd_line_in(wd_line_in),
    .stop_mode_select(stop_mode_select), .bus_disable_select(bus_disable_select),
    .ctrl_watchdog_gate_select(ctrl_watchdog_gate_select));
